//--- verilog/pdr_pkg.sv
// Package for the capability renegotiation block: register offsets,
// capability word fields and the message carrier.
// Assumes that the message layer beside it uses the same message codes.
package pdr_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  RX_SINK_CAP_OFS  = 8'h31; // Read only.
   localparam logic [7:0]  SRC_CAP_SET_OFS  = 8'h32; // Host writable.
   localparam logic [7:0]  TX_SINK_CAP_OFS  = 8'h33; // Host writable.
   localparam logic [31:0] RX_SINK_CAP_RST  = 32'h00000000;
   localparam logic [31:0] UNMAPPED_RDATA   = 32'h00000000;

   // ----------------------------------------------------------------
   // Capability and request word fields
   // ----------------------------------------------------------------
   localparam int          VOLT_MSB = 19; // Voltage field of an object.
   localparam int          VOLT_LSB = 10;
   localparam int          CURR_MSB = 9;  // Current field of an object.
   localparam int          CURR_LSB = 0;
   localparam int          POS_MSB  = 30; // Object position of a request.
   localparam int          POS_LSB  = 28;
   localparam int          MISMATCH_BIT = 26; // Capability mismatch.
   localparam logic [2:0]  POS_FIVE_VOLT = 3'h1; // Object 1 is 5 V.
   localparam logic [2:0]  POS_ADVERTISED = 3'h2; // Programmed object.
   localparam logic [2:0]  POS_NONE = 3'h0;

   // ----------------------------------------------------------------
   // Messages exchanged with the message layer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MSG_NONE,
      MSG_SRC_CAP,
      MSG_GET_SINK_CAP,
      MSG_SINK_CAP,
      MSG_REQUEST,
      MSG_ACCEPT,
      MSG_PS_READY
   } pdr_msg_kind_t;

   typedef struct packed {
      pdr_msg_kind_t kind; // Message type.
      logic [31:0]   data; // Single data object, zero when unused.
   } pdr_msg_t;

endpackage

//--- verilog/pdr_renegotiate.sv
// Command interpreter and capability registers of a power delivery
// port controller used to renegotiate a power contract.
// Assumes a message layer on the same clock that frames, checks and
// acknowledges messages, and a host on a simple register port.
`timescale 1ns/1ns

// Overview of operation
// - Resend command transmits current source capabilities
// - Query command asks sink caps, stores reply
// - Received sink register zero until reply arrives
// - Sink sends capabilities only when asked
// - Unmatched request sets capability mismatch bit
// - Host may write source capability register
// - Host may write transmitted sink capabilities
// - Accepted request is followed by PS_Ready
// - Object 1 request supplies only 5 V
module pdr_renegotiate
   import pdr_pkg::*;
#(
   parameter logic [31:0] SRC_CAP_RST     = 32'h00000000,
   parameter logic [31:0] TX_SINK_CAP_RST = 32'h00000000
) (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        is_source_i,
   input  wire logic        resend_source_caps_cmd_i,
   input  wire logic        query_sink_caps_cmd_i,
   input  wire logic        host_wr_i,
   input  wire logic [7:0]  host_addr_i,
   input  wire logic [31:0] host_wdata_i,
   output      logic [31:0] host_rdata_o,
   output      logic        tx_valid_o,
   output      pdr_msg_t    tx_msg_o,
   input  wire logic        tx_ready_i,
   input  wire logic        rx_valid_i,
   input  wire pdr_msg_t    rx_msg_i,
   output      logic [2:0]  contract_obj_o,
   output      logic        vbus_5v_only_o,
   output      logic        busy_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_WAIT_REQ} pdr_state_t;

   pdr_state_t  state_reg,        state_next;       // Sequencer state.
   pdr_msg_t    tx_msg_reg,       tx_msg_next;      // Message held out.
   logic [31:0] rx_sink_cap_reg,  rx_sink_cap_next; // Partner sink caps.
   logic [31:0] src_cap_reg,      src_cap_next;     // Offered object.
   logic [31:0] tx_sink_cap_reg,  tx_sink_cap_next; // Own sink object.
   logic [31:0] rdata_reg,        rdata_next;       // Read data.
   logic [2:0]  obj_reg,          obj_next;         // Contract object.
   logic        five_reg,         five_next;        // 5 V only supply.
   logic        valid_reg,        valid_next;       // Message offered.
   logic        busy_reg,         busy_next;        // Sequencer not idle.
   logic        match;       // Offered object meets own sink object.
   logic        tx_taken;    // Message layer took the held message.
   logic        rx_is_sink;  // Partner sink capabilities arrived.

   assign tx_taken   = (state_reg == ST_TX) && tx_ready_i;
   assign rx_is_sink = rx_valid_i && (rx_msg_i.kind == MSG_SINK_CAP);

   // A sink object matches when the voltage is equal and the offered
   // current covers what the sink asks. Lowering the host's sink
   // current therefore changes which object gets accepted.
   assign match =
      (rx_msg_i.data[VOLT_MSB:VOLT_LSB] ==
       tx_sink_cap_reg[VOLT_MSB:VOLT_LSB]) &&
      (rx_msg_i.data[CURR_MSB:CURR_LSB] >=
       tx_sink_cap_reg[CURR_MSB:CURR_LSB]);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Writes land in one cycle; reads return the addressed register one
   // cycle after the address is presented.
   always_comb begin
      src_cap_next     = src_cap_reg;
      tx_sink_cap_next = tx_sink_cap_reg;
      rx_sink_cap_next = rx_sink_cap_reg;
      if (host_wr_i && host_addr_i == SRC_CAP_SET_OFS) begin
         src_cap_next = host_wdata_i;
      end else if (host_wr_i && host_addr_i == TX_SINK_CAP_OFS) begin
         tx_sink_cap_next = host_wdata_i;
      end
      // Only a real reply fills the received register, and it replaces
      // the old word entirely; host writes here are ignored.
      if (rx_is_sink) begin
         rx_sink_cap_next = rx_msg_i.data;
      end
      if (host_addr_i == RX_SINK_CAP_OFS) begin
         rdata_next = rx_sink_cap_reg;
      end else if (host_addr_i == SRC_CAP_SET_OFS) begin
         rdata_next = src_cap_reg;
      end else if (host_addr_i == TX_SINK_CAP_OFS) begin
         rdata_next = tx_sink_cap_reg;
      end else begin
         rdata_next = UNMAPPED_RDATA;
      end
   end

   // Registering only; the reset leaves the received word cleared.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         src_cap_reg     <= SRC_CAP_RST;
         tx_sink_cap_reg <= TX_SINK_CAP_RST;
         rx_sink_cap_reg <= RX_SINK_CAP_RST;
         rdata_reg       <= UNMAPPED_RDATA;
      end else begin
         src_cap_reg     <= src_cap_next;
         tx_sink_cap_reg <= tx_sink_cap_next;
         rx_sink_cap_reg <= rx_sink_cap_next;
         rdata_reg       <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // Negotiation sequencer
   // ----------------------------------------------------------------
   // One message is held at a time. Commands and partner messages that
   // arrive while a message is in flight are dropped, which keeps the
   // sequencer simple; the host sees busy_o and retries.
   always_comb begin
      state_next  = state_reg;
      tx_msg_next = tx_msg_reg;
      obj_next    = obj_reg;
      five_next   = five_reg;
      case (state_reg)
         ST_IDLE: begin
            if (is_source_i && resend_source_caps_cmd_i) begin
               tx_msg_next = '{MSG_SRC_CAP, src_cap_reg};
               state_next  = ST_TX;
            end else if (is_source_i && query_sink_caps_cmd_i) begin
               tx_msg_next = '{MSG_GET_SINK_CAP, 32'h00000000};
               state_next  = ST_TX;
            end else if (!is_source_i && rx_valid_i &&
                         rx_msg_i.kind == MSG_GET_SINK_CAP) begin
               // Capabilities go out only on the partner's request.
               tx_msg_next = '{MSG_SINK_CAP, tx_sink_cap_reg};
               state_next  = ST_TX;
            end else if (!is_source_i && rx_valid_i &&
                         rx_msg_i.kind == MSG_SRC_CAP) begin
               // A sink always answers with a request; when nothing
               // matches it falls back to object 1 and flags it.
               tx_msg_next.kind = MSG_REQUEST;
               tx_msg_next.data = 32'h00000000;
               tx_msg_next.data[POS_MSB:POS_LSB] =
                  match ? POS_ADVERTISED : POS_FIVE_VOLT;
               tx_msg_next.data[MISMATCH_BIT] = !match;
               tx_msg_next.data[CURR_MSB:CURR_LSB] =
                  tx_sink_cap_reg[CURR_MSB:CURR_LSB];
               state_next = ST_TX;
            end
         end
         ST_TX: begin
            if (tx_ready_i) begin
               if (tx_msg_reg.kind == MSG_SRC_CAP) begin
                  state_next = ST_WAIT_REQ;
               end else if (tx_msg_reg.kind == MSG_ACCEPT) begin
                  tx_msg_next = '{MSG_PS_READY, 32'h00000000};
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_WAIT_REQ: begin
            if (rx_valid_i && rx_msg_i.kind == MSG_REQUEST) begin
               obj_next  = rx_msg_i.data[POS_MSB:POS_LSB];
               // Object 1 means 5 V whatever else was offered.
               five_next = (rx_msg_i.data[POS_MSB:POS_LSB] ==
                            POS_FIVE_VOLT);
               tx_msg_next = '{MSG_ACCEPT, 32'h00000000};
               state_next  = ST_TX;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      valid_next = (state_next == ST_TX);
      busy_next  = (state_next != ST_IDLE);
   end

   // Registering only; the port starts idle on the 5 V default.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg  <= ST_IDLE;
         tx_msg_reg <= '{MSG_NONE, 32'h00000000};
         obj_reg    <= POS_NONE;
         five_reg   <= 1'b1;
         valid_reg  <= 1'b0;
         busy_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         tx_msg_reg <= tx_msg_next;
         obj_reg    <= obj_next;
         five_reg   <= five_next;
         valid_reg  <= valid_next;
         busy_reg   <= busy_next;
      end
   end

   assign host_rdata_o   = rdata_reg;
   assign tx_valid_o     = valid_reg;
   assign tx_msg_o       = tx_msg_reg;
   assign contract_obj_o = obj_reg;
   assign vbus_5v_only_o = five_reg;
   assign busy_o         = busy_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_resend;
      @(posedge clk_i) disable iff (srst_i)
      (state_reg == ST_IDLE && is_source_i && resend_source_caps_cmd_i)
      |=> tx_valid_o && tx_msg_o.kind == MSG_SRC_CAP &&
          tx_msg_o.data == $past(src_cap_reg);
   endproperty
   a_resend: assert property (p_resend)
      else $error("Resend did not send source capabilities.");

   property p_query;
      @(posedge clk_i) disable iff (srst_i)
      (state_reg == ST_IDLE && is_source_i && !resend_source_caps_cmd_i
       && query_sink_caps_cmd_i)
      |=> tx_valid_o && tx_msg_o.kind == MSG_GET_SINK_CAP;
   endproperty
   a_query: assert property (p_query)
      else $error("Query did not send Get Sink Capabilities.");

   property p_rx_only;
      @(posedge clk_i) disable iff (srst_i)
      !$stable(rx_sink_cap_reg) && !$past(srst_i) |-> $past(rx_is_sink);
   endproperty
   a_rx_only: assert property (p_rx_only)
      else $error("Received sink register changed without a reply.");

   property p_sink_on_ask;
      @(posedge clk_i) disable iff (srst_i)
      $rose(tx_valid_o) && tx_msg_o.kind == MSG_SINK_CAP
      |-> $past(rx_valid_i) && $past(rx_msg_i.kind) == MSG_GET_SINK_CAP;
   endproperty
   a_sink_on_ask: assert property (p_sink_on_ask)
      else $error("Sink capabilities sent unasked.");

   property p_mismatch;
      @(posedge clk_i) disable iff (srst_i)
      $rose(tx_valid_o) && tx_msg_o.kind == MSG_REQUEST
      |-> tx_msg_o.data[MISMATCH_BIT] == !$past(match) &&
          (tx_msg_o.data[POS_MSB:POS_LSB] == POS_FIVE_VOLT) ==
          !$past(match);
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("Mismatch bit disagrees with object match.");

   property p_src_wr;
      @(posedge clk_i) disable iff (srst_i)
      host_wr_i && host_addr_i == SRC_CAP_SET_OFS
      |=> src_cap_reg == $past(host_wdata_i) ##1
          (host_rdata_o == $past(src_cap_reg, 1) ||
           $past(host_addr_i) != SRC_CAP_SET_OFS);
   endproperty
   a_src_wr: assert property (p_src_wr)
      else $error("Source capability write lost.");

   property p_tx_sink_wr;
      @(posedge clk_i) disable iff (srst_i)
      host_wr_i && host_addr_i == TX_SINK_CAP_OFS
      |=> tx_sink_cap_reg == $past(host_wdata_i);
   endproperty
   a_tx_sink_wr: assert property (p_tx_sink_wr)
      else $error("Transmit sink capability write lost.");

   property p_ps_ready;
      @(posedge clk_i) disable iff (srst_i)
      tx_taken && tx_msg_o.kind == MSG_ACCEPT
      |=> tx_valid_o && tx_msg_o.kind == MSG_PS_READY;
   endproperty
   a_ps_ready: assert property (p_ps_ready)
      else $error("Accept was not followed by PS_Ready.");

   property p_five_volt;
      @(posedge clk_i) disable iff (srst_i)
      state_reg == ST_WAIT_REQ && rx_valid_i &&
      rx_msg_i.kind == MSG_REQUEST &&
      rx_msg_i.data[POS_MSB:POS_LSB] == POS_FIVE_VOLT
      |=> vbus_5v_only_o && contract_obj_o == POS_FIVE_VOLT;
   endproperty
   a_five_volt: assert property (p_five_volt)
      else $error("Object 1 contract not limited to 5 V.");

   property p_replace;
      @(posedge clk_i) disable iff (srst_i)
      rx_is_sink |=> rx_sink_cap_reg == $past(rx_msg_i.data);
   endproperty
   a_replace: assert property (p_replace)
      else $error("Received capabilities not fully replaced.");

endmodule

//--- verification/pdr_partner_model.sv
// Behavioural port partner: a sink-side controller and its message
// layer facing the renegotiation block. Assumes the bench clock.
`timescale 1ns/1ns
module pdr_partner_model
   import pdr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic [1:0]  slow_i,      // Cycles held off before ready.
   input  wire logic        tx_valid_i,
   input  wire pdr_msg_t    tx_msg_i,
   output      logic        tx_ready_o,
   input  wire logic [31:0] req_word_i,  // Request object sent back.
   input  wire logic [31:0] sink_word_i, // Sink object sent when asked.
   input  wire logic        inj_i,       // Bench injects a message.
   input  wire pdr_msg_t    inj_msg_i,
   output      logic        rx_valid_o,
   output      pdr_msg_t    rx_msg_o
);
   // ----------------------------------------------------------------
   // Handshake and replies
   // ----------------------------------------------------------------
   pdr_msg_kind_t got = MSG_NONE;  // Kind taken at the last edge.
   logic [1:0]    wait_cnt = 2'h0; // Cycles the block has waited.
   logic          own_vld = 1'b0;  // Own reply is on the lines.
   pdr_msg_t      own_msg = '0;    // Own reply, or a toggling pattern.
   initial tx_ready_o = 1'b0;

   // Note what the block handed over at this edge.
   always @(posedge clk_i) begin
      got <= (tx_valid_i && tx_ready_o) ? tx_msg_i.kind : MSG_NONE;
   end

   // Act after the edge; released data toggles so it never looks held.
   always @(negedge clk_i) begin
      own_vld <= 1'b0;
      own_msg <= pdr_msg_t'(~own_msg);
      if (got == MSG_SRC_CAP) begin
         own_vld <= 1'b1;
         own_msg <= '{MSG_REQUEST, req_word_i};
      end else if (got == MSG_GET_SINK_CAP) begin
         own_vld <= 1'b1;
         own_msg <= '{MSG_SINK_CAP, sink_word_i};
      end
      wait_cnt <= (tx_valid_i && !tx_ready_o) ? wait_cnt + 2'h1 : 2'h0;
      tx_ready_o <= tx_valid_i && !tx_ready_o && (wait_cnt >= slow_i);
   end

   assign rx_valid_o = own_vld | inj_i;
   assign rx_msg_o   = inj_i ? inj_msg_i : own_msg;
endmodule

//--- verification/tb.sv
// Self-checking bench for the renegotiation block and a partner model.
// Assumes the design package and the partner model compile first.
`timescale 1ns/1ns
module tb;
   import pdr_pkg::*;
   // ----------------------------------------------------------------
   // Values and signals
   // ----------------------------------------------------------------
   localparam logic [31:0] SRC_RST = 32'h0001902C; // Reset source object.
   localparam logic [31:0] SNK_RST = 32'h00019014; // Reset sink object.
   localparam logic [31:0] D1 = 32'h000640AF; // High voltage object.
   localparam logic [31:0] D2 = 32'h00064096; // Same volt, less current.
   localparam logic [31:0] D3 = 32'h0006408C;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } pdr_row_t;
   logic        clk = 0, srst = 1, is_src = 1, rs_cmd = 0, qs_cmd = 0;
   logic        hwr = 0, txv, txr, rxv, v5, busy, inj = 0;
   logic [7:0]  haddr = 8'h00;
   logic [31:0] hwdata = '0, hrdata, reqw = '0, sinkw = '0;
   logic [2:0]  cobj;
   logic [1:0]  slow = 2'h0;
   pdr_msg_t    txm, rxm, injm = '0;
   pdr_msg_t    log_q[$]; // Every message the block handed over.
   int          err_total = 0, num_checks = 0;

   always #20 clk = ~clk;
   always @(posedge clk) if (txv && txr) log_q.push_back(txm);

   pdr_renegotiate #(.SRC_CAP_RST(SRC_RST), .TX_SINK_CAP_RST(SNK_RST)) dut (
      .clk_i(clk), .srst_i(srst), .is_source_i(is_src),
      .resend_source_caps_cmd_i(rs_cmd), .query_sink_caps_cmd_i(qs_cmd),
      .host_wr_i(hwr), .host_addr_i(haddr), .host_wdata_i(hwdata),
      .host_rdata_o(hrdata), .tx_valid_o(txv), .tx_msg_o(txm),
      .tx_ready_i(txr), .rx_valid_i(rxv), .rx_msg_i(rxm),
      .contract_obj_o(cobj), .vbus_5v_only_o(v5), .busy_o(busy));
   pdr_partner_model partner (
      .clk_i(clk), .slow_i(slow), .tx_valid_i(txv), .tx_msg_i(txm),
      .tx_ready_o(txr), .req_word_i(reqw), .sink_word_i(sinkw),
      .inj_i(inj), .inj_msg_i(injm), .rx_valid_o(rxv), .rx_msg_o(rxm));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [34:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (err_total == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hwr = 1;
      haddr = a;
      hwdata = d;
      @(negedge clk);
      hwr = 0;
   endtask
   // Read data is registered, so it is looked at one cycle later.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      haddr = a;
      @(negedge clk);
      check("rdata", {3'h0, hrdata}, {3'h0, e});
   endtask
   task automatic pulse(input bit q);
      if (q) qs_cmd = 1; else rs_cmd = 1;
      @(negedge clk);
      if (q) qs_cmd = 0; else rs_cmd = 0;
   endtask
   task automatic inject(input pdr_msg_kind_t k, input logic [31:0] d);
      inj = 1;
      injm = '{k, d};
      @(negedge clk);
      inj = 0;
   endtask
   // Bounded wait for n logged messages; two more cycles let replies land.
   task automatic wait_log(input int n);
      int k;
      for (k = 0; k < 60 && (log_q.size() < n || txv); k++) @(negedge clk);
      if (log_q.size() < n || txv) begin
         err_total++;
         $display("BAD timeout expected %0d seen %0d", n, log_q.size());
         finish_test();
      end
      repeat (2) @(negedge clk);
   endtask
   function automatic logic [31:0] mk_req(input logic [2:0] p,
                                          input logic m,
                                          input logic [9:0] c);
      mk_req = '0;
      mk_req[POS_MSB:POS_LSB] = p;
      mk_req[MISMATCH_BIT] = m;
      mk_req[CURR_MSB:CURR_LSB] = c;
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      pdr_row_t rows [4];
      int i;
      rows = '{'{SRC_CAP_SET_OFS, D1, D1}, '{TX_SINK_CAP_OFS, D2, D2},
               '{RX_SINK_CAP_OFS, D3, 32'h0}, '{8'h40, D3, 32'h0}};
      repeat (4) @(negedge clk);
      srst = 0;
      check("idle", {busy, txv, v5, cobj}, {3'b001, 3'h0});
      rd(RX_SINK_CAP_OFS, RX_SINK_CAP_RST);
      rd(TX_SINK_CAP_OFS, SNK_RST);
      for (i = 0; i < 4; i++) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].exp);
      end
      // Two queries; the second reply has fewer bits set than the first.
      sinkw = 32'h0006412C;
      pulse(1);
      wait_log(1);
      check("tx", log_q[0], {MSG_GET_SINK_CAP, 32'h0});
      rd(RX_SINK_CAP_OFS, 32'h0006412C);
      sinkw = 32'h00030010;
      pulse(1);
      wait_log(2);
      rd(RX_SINK_CAP_OFS, 32'h00030010);
      // Resend with a prompt partner that takes the advertised object.
      log_q.delete();
      reqw = mk_req(POS_ADVERTISED, 1'b0, 10'h096);
      pulse(0);
      wait_log(3);
      check("tx", log_q[0], {MSG_SRC_CAP, D1});
      check("tx", log_q[1], {MSG_ACCEPT, 32'h0});
      check("tx", log_q[2], {MSG_PS_READY, 32'h0});
      check("obj", {cobj, v5}, {POS_ADVERTISED, 1'b0});
      // New object, slow partner, object 1 and a query while busy.
      log_q.delete();
      wr(SRC_CAP_SET_OFS, D3);
      slow = 2'h2;
      reqw = mk_req(POS_FIVE_VOLT, 1'b1, 10'h096);
      pulse(0);
      check("busy", busy, 1'b1);
      pulse(1);
      wait_log(3);
      check("count", log_q.size(), 3);
      check("tx", log_q[0], {MSG_SRC_CAP, D3});
      check("obj", {cobj, v5}, {POS_FIVE_VOLT, 1'b1});
      // Sink role: commands are dropped, offers get requests.
      log_q.delete();
      is_src = 0;
      slow = 2'h0;
      pulse(0);
      inject(MSG_SRC_CAP, D1);
      wait_log(1);
      check("tx", log_q[0],
            {MSG_REQUEST, mk_req(POS_ADVERTISED, 1'b0, 10'h096)});
      inject(MSG_SRC_CAP, 32'h0004B12C);
      wait_log(2);
      check("tx", log_q[1],
            {MSG_REQUEST, mk_req(POS_FIVE_VOLT, 1'b1, 10'h096)});
      inject(MSG_GET_SINK_CAP, 32'h0);
      wait_log(3);
      check("tx", log_q[2], {MSG_SINK_CAP, D2});
      check("count", log_q.size(), 3);
      // Reset in mid-run clears the received register again.
      srst = 1;
      @(negedge clk);
      srst = 0;
      check("obj", {cobj, v5}, {POS_NONE, 1'b1});
      rd(RX_SINK_CAP_OFS, RX_SINK_CAP_RST);
      rd(SRC_CAP_SET_OFS, SRC_RST);
      finish_test();
   end
endmodule
